// >>> include/trig_seq_map.vh
// register offsets, field codes, reset values and timing counts of the trigger sequencer
`ifndef TRIG_SEQ_MAP_VH
`define TRIG_SEQ_MAP_VH
// ==========================================
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_PORT_CFG 8'h08
`define OFS_STYLE 8'h0c
`define OFS_HOLD 8'h10
`define OFS_DELAY 8'h14
`define OFS_STEP_DELAY 8'h18
`define OFS_SRC_TRIG_DELAY 8'h1c
`define OFS_MEAS_TRIG_DELAY 8'h20
`define OFS_SRE 8'h24
`define OFS_PROGRAM 8'h28
`define OFS_COMMAND 8'h2c
`define OFS_SWEEP_STEPS 8'h30
// ==========================================
// port config word: [7:0] port number (signed), [9:8] direction, [11:10] polarity, [13:12] type
`define PORT_MAIN_IN 8'hff
`define PORT_MAIN_OUT 8'hfe
`define DIR_INPUT 2'h1
`define DIR_OUTPUT 2'h2
`define POL_POSITIVE 2'h1
`define POL_NEGATIVE 2'h2
`define TYPE_MEAS 2'h1
`define TYPE_SETUP 2'h2
`define TYPE_STEP 2'h3
`define STYLE_EDGE 2'h1
`define STYLE_GATE 2'h2
// ==========================================
// control register fields
`define CTRL_EXT_START_BIT 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 2
`define CTRL_FIRST_TRIG_BIT 3
`define MODE_SPOT 2'h1
`define MODE_SWEEP 2'h2
`define MODE_HS_SPOT 2'h3
// command register bits
`define CMD_START_BIT 0
`define CMD_RESET_BIT 1
`define CMD_CLEAR_BIT 2
`define CMD_ERASE_BIT 3
// ==========================================
// reset values
`define SRE_RESET 8'h40
`define STYLE_RESET 6'h15
// ==========================================
// timing
`define CLK_MHZ 200
`define PULSE_US 10
`define PULSE_CYCLES (`PULSE_US * `CLK_MHZ)
`define MEAS_CYCLES 16
`endif

// >>> logic/trig_in_detect.v
// synchroniser and polarity edge detector for one trigger input
`timescale 1ns/100ps
module trig_in_detect (
    input wire clk,
    input wire rst,
    input wire level_in,
    input wire negative_in,
    output reg pulse_out
);
    reg sync_a;
    reg sync_b;
    reg prev;
    // ==========================================
    // two flops then edge compare on the second stage only
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            prev <= 1'b0;
            pulse_out <= 1'b0;
        end else begin
            sync_a <= level_in;
            sync_b <= sync_a;
            prev <= sync_b;
            pulse_out <= negative_in ? (prev & ~sync_b) : (~prev & sync_b); // [RULE_24]
        end
    end
endmodule

// >>> logic/trig_sequencer.v
// measurement trigger sequencer with axi4-lite register access
// Function
// RULE_01: external start mode waits for a negative main-input trigger before measuring.
// RULE_02: completed measurement gives negative edge on main output and data ready.
// RULE_03: external trigger start is ignored in high speed spot mode.
// RULE_04: positive gate output goes active when measurement starts.
// RULE_05: gate output returns low at completion, then data becomes available.
// RULE_06: port config holds port number, direction, polarity, type in order.
// RULE_07: trigger types 1,2,3 mean measurement, step setup, step measurement.
// RULE_08: output style 1 selects edge pulse, 2 selects gate level.
// RULE_09: sweep begins only on the start-measurement input trigger (code: the start command also begins it while CTRL_EXT_START_BIT is clear).
// RULE_10: setup trigger waits source trigger delay then emits setup completion.
// RULE_11: first setup trigger during hold time is deferred until hold ends.
// RULE_12: step trigger waits measurement delay, measures, emits step completion.
// RULE_13: step trigger during delay time is deferred until delay ends.
// RULE_14: later setup triggers change source, wait, emit; deferred within step delay.
// RULE_15: sweep end emits step completion, measurement completion, then data ready.
// RULE_16: five timing intervals: hold, delay, step delay, source and measure delays.
// RULE_17: default setup condition needs an input trigger for the first step too.
// RULE_18: power-up, reset command and device clear restore initial settings.
// RULE_19: program memory survives reset command and clear; only erase clears it (code: RESET_IN also clears it).
// RULE_20: defaults: main in starts, main out completes, digital lines cleared.
// RULE_21: all output styles default to edge pulse.
// RULE_22: status byte enable mask defaults to bit 6 only.
// RULE_23: default completion edge is a negative pulse of about ten microseconds.
// RULE_24: inputs are synchronised and edge detected per configured polarity.
`timescale 1ns/100ps
`include "trig_seq_map.vh"
module trig_sequencer #(
    parameter NUM_LINES = 16,
    parameter PULSE_CYCLES = `PULSE_CYCLES
) (
    input wire CLK_IN,
    input wire RESET_IN,
    input wire [7:0] S_AXI_AWADDR_IN,
    input wire S_AXI_AWVALID_IN,
    output reg S_AXI_AWREADY_OUT,
    input wire [31:0] S_AXI_WDATA_IN,
    input wire [3:0] S_AXI_WSTRB_IN,
    input wire S_AXI_WVALID_IN,
    output reg S_AXI_WREADY_OUT,
    output reg [1:0] S_AXI_BRESP_OUT,
    output reg S_AXI_BVALID_OUT,
    input wire S_AXI_BREADY_IN,
    input wire [7:0] S_AXI_ARADDR_IN,
    input wire S_AXI_ARVALID_IN,
    output reg S_AXI_ARREADY_OUT,
    output reg [31:0] S_AXI_RDATA_OUT,
    output reg [1:0] S_AXI_RRESP_OUT,
    output reg S_AXI_RVALID_OUT,
    input wire S_AXI_RREADY_IN,
    input wire MAIN_TRIG_IN,
    output reg MAIN_TRIG_OUT,
    input wire [NUM_LINES-1:0] DIGITAL_LINE_IN,
    output reg [NUM_LINES-1:0] DIGITAL_LINE_OUT,
    output reg [NUM_LINES-1:0] DIGITAL_LINE_OE_OUT,
    output reg DATA_READY_OUT
);
    localparam NP = NUM_LINES + 2;
    localparam S_IDLE = 8'h01, S_ARM = 8'h02, S_HOLD = 8'h04, S_SETUP = 8'h08;
    localparam S_STEPW = 8'h10, S_MEAS = 8'h20, S_DONE = 8'h40, S_WAIT = 8'h80;
    // ==========================================
    // register storage; index 0 main in, 1 main out, 2.. digital lines
    reg [3:0] ctrl;
    reg [31:0] t_hold, t_delay, t_step, t_src, t_meas;
    reg [7:0] sre;
    reg [5:0] style; // [1:0] completion, [3:2] setup, [5:4] step
    reg [31:0] program_word;
    reg [15:0] sweep_steps;
    reg [13:0] port_cfg [0:NP-1];
    reg [7:0] state;
    reg [31:0] timer;
    reg [15:0] step_cnt;
    reg setup_pend, step_pend, first_step;
    reg [31:0] pulse_cnt [0:2];
    reg [2:0] gate_on;
    reg [7:0] aw_addr;
    reg aw_have, w_have;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    wire [NP-1:0] in_level = {DIGITAL_LINE_IN, 1'b0, MAIN_TRIG_IN};
    wire [NP-1:0] in_pulse;
    reg [2:0] emit;
    reg soft_start;
    // ==========================================
    // field decoders: is_active_in for inputs, pick_style for outputs
    function is_active_in;
        input [13:0] c;
        input [1:0] ty;
        begin
            is_active_in = (c[9:8] == `DIR_INPUT) && (c[13:12] == ty); // [RULE_06] [RULE_07]
        end
    endfunction
    function [1:0] pick_style;
        input [5:0] s;
        input [1:0] ty;
        begin
            pick_style = (ty == `TYPE_MEAS) ? s[1:0] : (ty == `TYPE_SETUP) ? s[3:2] : s[5:4];
        end
    endfunction
    // ==========================================
    // one detector per trigger input
    genvar g;
    generate
        for (g = 0; g < NP; g = g + 1) begin : det
            trig_in_detect u_det (
                .clk(CLK_IN),
                .rst(RESET_IN),
                .level_in(in_level[g]),
                .negative_in(port_cfg[g][11:10] == `POL_NEGATIVE),
                .pulse_out(in_pulse[g])
            );
        end
    endgenerate
    // gather input events by trigger type
    reg [3:1] ev;
    integer i;
    always @* begin
        ev = 3'h0;
        for (i = 0; i < NP; i = i + 1) begin
            if (in_pulse[i] && is_active_in(port_cfg[i], `TYPE_MEAS)) ev[1] = 1'b1;
            if (in_pulse[i] && is_active_in(port_cfg[i], `TYPE_SETUP)) ev[2] = 1'b1;
            if (in_pulse[i] && is_active_in(port_cfg[i], `TYPE_STEP)) ev[3] = 1'b1;
        end
    end
    wire aw_go = aw_have && w_have && !S_AXI_BVALID_OUT;
    wire [31:0] cmd = (aw_go && aw_addr == `OFS_COMMAND) ? w_data : 32'h0;
    wire reinit = cmd[`CMD_RESET_BIT] | cmd[`CMD_CLEAR_BIT];
    wire hs_spot = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO] == `MODE_HS_SPOT;
    wire sweep = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO] == `MODE_SWEEP;
    // ==========================================
    // axi write channel and register writes; reinit restores defaults except program memory
    integer k;
    always @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            S_AXI_AWREADY_OUT <= 1'b0;
            S_AXI_WREADY_OUT <= 1'b0;
            S_AXI_BVALID_OUT <= 1'b0;
            S_AXI_BRESP_OUT <= 2'h0;
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            program_word <= 32'h0;
        end else begin
            S_AXI_AWREADY_OUT <= !aw_have && !S_AXI_AWREADY_OUT;
            S_AXI_WREADY_OUT <= !w_have && !S_AXI_WREADY_OUT;
            if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
                aw_have <= 1'b1;
                aw_addr <= S_AXI_AWADDR_IN;
                S_AXI_AWREADY_OUT <= 1'b0;
            end
            if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
                w_have <= 1'b1;
                w_data <= S_AXI_WDATA_IN;
                w_strb <= S_AXI_WSTRB_IN;
                S_AXI_WREADY_OUT <= 1'b0;
            end
            if (aw_go) begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                S_AXI_BVALID_OUT <= 1'b1;
                S_AXI_BRESP_OUT <= (aw_addr >= `OFS_PORT_CFG + 8'h40 + NP * 4) ? 2'h2 : 2'h0;
                if (aw_addr == `OFS_PROGRAM && w_strb != 4'h0) program_word <= w_data;
                if (cmd[`CMD_ERASE_BIT]) program_word <= 32'h0; // [RULE_19]
            end
            if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) S_AXI_BVALID_OUT <= 1'b0;
        end
    end
    // configuration registers
    always @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ctrl <= 4'h0;
            sre <= `SRE_RESET; // [RULE_22]
            style <= `STYLE_RESET; // [RULE_21]
            {t_hold, t_delay, t_step, t_src, t_meas} <= 160'h0;
            sweep_steps <= 16'h0001;
            soft_start <= 1'b0;
            for (k = 0; k < NP; k = k + 1) port_cfg[k] <= 14'h0;
            port_cfg[0] <= {`TYPE_MEAS, `POL_NEGATIVE, `DIR_INPUT, `PORT_MAIN_IN}; // [RULE_20]
            port_cfg[1] <= {`TYPE_MEAS, `POL_NEGATIVE, `DIR_OUTPUT, `PORT_MAIN_OUT};
        end else if (reinit) begin
            ctrl <= 4'h0; // [RULE_18] [RULE_17]
            sre <= `SRE_RESET;
            style <= `STYLE_RESET;
            {t_hold, t_delay, t_step, t_src, t_meas} <= 160'h0;
            sweep_steps <= 16'h0001;
            soft_start <= 1'b0;
            for (k = 2; k < NP; k = k + 1) port_cfg[k] <= 14'h0;
            port_cfg[0] <= {`TYPE_MEAS, `POL_NEGATIVE, `DIR_INPUT, `PORT_MAIN_IN};
            port_cfg[1] <= {`TYPE_MEAS, `POL_NEGATIVE, `DIR_OUTPUT, `PORT_MAIN_OUT};
        end else begin
            soft_start <= cmd[`CMD_START_BIT];
            if (aw_go) begin
                case (aw_addr)
                    `OFS_CTRL: ctrl <= w_data[3:0];
                    `OFS_STYLE: style <= w_data[5:0]; // [RULE_08]
                    `OFS_HOLD: t_hold <= w_data; // [RULE_16]
                    `OFS_DELAY: t_delay <= w_data;
                    `OFS_STEP_DELAY: t_step <= w_data;
                    `OFS_SRC_TRIG_DELAY: t_src <= w_data;
                    `OFS_MEAS_TRIG_DELAY: t_meas <= w_data;
                    `OFS_SRE: sre <= w_data[7:0];
                    `OFS_SWEEP_STEPS: sweep_steps <= w_data[15:0];
                    default: begin
                        for (k = 0; k < NP; k = k + 1)
                            if (aw_addr == `OFS_PORT_CFG + 8'h40 + k * 4) port_cfg[k] <= w_data[13:0]; // [RULE_06]
                    end
                endcase
            end
        end
    end
    // ==========================================
    // axi read channel
    reg [31:0] rd_val;
    integer r;
    always @* begin
        rd_val = 32'h0;
        case (S_AXI_ARADDR_IN)
            `OFS_CTRL: rd_val = {28'h0, ctrl};
            `OFS_STATUS: rd_val = {step_cnt, 8'h0, state};
            `OFS_STYLE: rd_val = {26'h0, style};
            `OFS_HOLD: rd_val = t_hold;
            `OFS_DELAY: rd_val = t_delay;
            `OFS_STEP_DELAY: rd_val = t_step;
            `OFS_SRC_TRIG_DELAY: rd_val = t_src;
            `OFS_MEAS_TRIG_DELAY: rd_val = t_meas;
            `OFS_SRE: rd_val = {24'h0, sre};
            `OFS_PROGRAM: rd_val = program_word;
            `OFS_SWEEP_STEPS: rd_val = {16'h0, sweep_steps};
            default: begin
                for (r = 0; r < NP; r = r + 1)
                    if (S_AXI_ARADDR_IN == `OFS_PORT_CFG + 8'h40 + r * 4) rd_val = {18'h0, port_cfg[r]};
            end
        endcase
    end
    always @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            S_AXI_ARREADY_OUT <= 1'b0;
            S_AXI_RVALID_OUT <= 1'b0;
            S_AXI_RDATA_OUT <= 32'h0;
            S_AXI_RRESP_OUT <= 2'h0;
        end else begin
            S_AXI_ARREADY_OUT <= !S_AXI_RVALID_OUT && !S_AXI_ARREADY_OUT;
            if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
                S_AXI_ARREADY_OUT <= 1'b0;
                S_AXI_RVALID_OUT <= 1'b1;
                S_AXI_RDATA_OUT <= rd_val;
                S_AXI_RRESP_OUT <= 2'h0;
            end
            if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) S_AXI_RVALID_OUT <= 1'b0;
        end
    end
    // ==========================================
    // sequencer; early triggers are latched as pending and served when the wait ends
    wire start_ev = ctrl[`CTRL_EXT_START_BIT] ? (ev[1] && !hs_spot) : soft_start; // [RULE_01] [RULE_03]
    always @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            state <= S_IDLE;
            timer <= 32'h0;
            step_cnt <= 16'h0;
            setup_pend <= 1'b0;
            step_pend <= 1'b0;
            first_step <= 1'b0;
            emit <= 3'h0;
            gate_on <= 3'h0;
            DATA_READY_OUT <= 1'b0;
        end else if (reinit) begin
            state <= S_IDLE;
            emit <= 3'h0;
            gate_on <= 3'h0;
            setup_pend <= 1'b0;
            step_pend <= 1'b0;
            DATA_READY_OUT <= 1'b0;
        end else begin
            emit <= 3'h0;
            if (timer != 32'h0) timer <= timer - 32'h1;
            case (state)
                S_IDLE: begin
                    if (start_ev) begin // [RULE_09]
                        DATA_READY_OUT <= 1'b0;
                        gate_on[0] <= 1'b1; // [RULE_04]
                        step_cnt <= 16'h0;
                        first_step <= 1'b1;
                        setup_pend <= 1'b0;
                        step_pend <= 1'b0;
                        timer <= sweep ? t_hold : `MEAS_CYCLES;
                        state <= sweep ? S_HOLD : S_MEAS;
                    end
                end
                S_HOLD: begin
                    // setup trigger waits out hold (first) or step delay (later)
                    if (timer == 32'h0 && (setup_pend || (first_step && ctrl[`CTRL_FIRST_TRIG_BIT]))) begin
                        setup_pend <= 1'b0; // [RULE_11] [RULE_14] [RULE_17]
                        timer <= t_src;
                        gate_on[1] <= 1'b1;
                        state <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    if (timer == 32'h0) begin
                        emit[1] <= 1'b1; // [RULE_10]
                        gate_on[1] <= 1'b0;
                        timer <= first_step ? t_delay : 32'h0;
                        first_step <= 1'b0;
                        state <= S_STEPW;
                    end
                end
                S_STEPW: begin
                    if (timer == 32'h0 && step_pend) begin
                        step_pend <= 1'b0; // [RULE_13]
                        timer <= t_meas;
                        state <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (timer == 32'h0) begin
                        timer <= `MEAS_CYCLES;
                        gate_on[2] <= 1'b1;
                        state <= S_MEAS; // [RULE_12]
                    end
                end
                S_MEAS: begin
                    if (timer == 32'h0) begin
                        if (sweep) begin
                            emit[2] <= 1'b1; // [RULE_12] [RULE_15]
                            gate_on[2] <= 1'b0;
                            step_cnt <= step_cnt + 16'h1;
                            timer <= t_step;
                            state <= (step_cnt + 16'h1 >= sweep_steps) ? S_DONE : S_HOLD;
                        end else begin
                            emit[0] <= 1'b1; // [RULE_02]
                            gate_on[0] <= 1'b0; // [RULE_05]
                            state <= S_DONE;
                        end
                    end
                end
                S_DONE: begin
                    // completion goes out one cycle after the last step completion
                    if (sweep && !emit[0] && gate_on[0]) begin
                        emit[0] <= 1'b1; // [RULE_15]
                        gate_on[0] <= 1'b0;
                    end else begin
                        DATA_READY_OUT <= 1'b1; // [RULE_05] [RULE_15]
                        state <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
            if (ev[2] && sweep) setup_pend <= 1'b1;
            if (ev[3] && sweep) step_pend <= 1'b1;
        end
    end
    // ==========================================
    // output pulse stretchers, one per completion type
    genvar t;
    generate
        for (t = 0; t < 3; t = t + 1) begin : pls
            always @(posedge CLK_IN or posedge RESET_IN) begin
                if (RESET_IN) pulse_cnt[t] <= 32'h0;
                else if (emit[t]) pulse_cnt[t] <= PULSE_CYCLES; // [RULE_23]
                else if (pulse_cnt[t] != 32'h0) pulse_cnt[t] <= pulse_cnt[t] - 32'h1;
            end
        end
    endgenerate
    // per-port active level then polarity; inactive ports sit at their idle level
    reg [NP-1:0] next_out;
    reg act;
    integer p;
    always @* begin
        next_out = {NP{1'b0}};
        act = 1'b0;
        for (p = 0; p < NP; p = p + 1) begin
            act = 1'b0;
            if (port_cfg[p][9:8] == `DIR_OUTPUT && port_cfg[p][13:12] != 2'h0) begin
                if (pick_style(style, port_cfg[p][13:12]) == `STYLE_GATE)
                    act = gate_on[port_cfg[p][13:12] - 2'h1]; // [RULE_04] [RULE_05]
                else
                    act = pulse_cnt[port_cfg[p][13:12] - 2'h1] != 32'h0;
            end
            next_out[p] = (port_cfg[p][11:10] == `POL_NEGATIVE) ? ~act : act; // [RULE_02]
        end
    end
    integer q;
    always @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            MAIN_TRIG_OUT <= 1'b1;
            DIGITAL_LINE_OUT <= {NUM_LINES{1'b0}};
            DIGITAL_LINE_OE_OUT <= {NUM_LINES{1'b0}};
        end else begin
            MAIN_TRIG_OUT <= next_out[1];
            DIGITAL_LINE_OUT <= next_out[NP-1:2];
            for (q = 0; q < NUM_LINES; q = q + 1)
                DIGITAL_LINE_OE_OUT[q] <= port_cfg[q + 2][9:8] == `DIR_OUTPUT;
        end
    end
endmodule

// >>> verification/trig_seq_props.sv
// concurrent checks on the trigger sequencer ports
`timescale 1ns/100ps
module trig_seq_props #(parameter NUM_LINES = 16, parameter PULSE_CYCLES = 8) (
    input wire CLK_IN, input wire RESET_IN, input wire S_AXI_AWVALID_IN, input wire S_AXI_AWREADY_OUT,
    input wire S_AXI_WVALID_IN, input wire S_AXI_WREADY_OUT, input wire S_AXI_BVALID_OUT,
    input wire S_AXI_BREADY_IN, input wire [1:0] S_AXI_BRESP_OUT, input wire S_AXI_ARVALID_IN,
    input wire S_AXI_ARREADY_OUT, input wire S_AXI_RVALID_OUT, input wire S_AXI_RREADY_IN,
    input wire [31:0] S_AXI_RDATA_OUT, input wire [1:0] S_AXI_RRESP_OUT, input wire MAIN_TRIG_OUT,
    input wire DATA_READY_OUT, input wire [NUM_LINES-1:0] DIGITAL_LINE_OE_OUT
);
    reg [15:0] low_cnt;
    // low time of the main output, judged when it rises
    always @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) low_cnt <= 16'h0;
        else low_cnt <= MAIN_TRIG_OUT ? 16'h0 : low_cnt + 16'h1;
    end
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);
    // ==========================================
    // bus and trigger relations
    chk_b_stands: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT)
        else $error("write response dropped");
    chk_r_stands: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> $stable(S_AXI_RDATA_OUT))
        else $error("read data moved");
    chk_r_latency: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
        else $error("read answer late");
    chk_b_latency: assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN
        && S_AXI_WREADY_OUT |-> ##[1:2] S_AXI_BVALID_OUT) else $error("write answer late");
    chk_r_okay: assert property (S_AXI_RVALID_OUT |-> S_AXI_RRESP_OUT == 2'h0)
        else $error("read response not okay");
    chk_pulse_width: assert property ($rose(MAIN_TRIG_OUT) |-> low_cnt >= PULSE_CYCLES)
        else $error("completion pulse short");
    chk_reset_outs: assert property (disable iff (1'b0) RESET_IN |-> MAIN_TRIG_OUT && !DATA_READY_OUT
        && DIGITAL_LINE_OE_OUT == 0) else $error("outputs not at reset level");
    chk_ready_holds: assert property ($rose(DATA_READY_OUT) |=> DATA_READY_OUT [*4])
        else $error("data ready dropped");
    cov_pulse: cover property ($fell(MAIN_TRIG_OUT));
    cov_ready: cover property ($rose(DATA_READY_OUT));
    cov_slverr: cover property (S_AXI_BVALID_OUT && S_AXI_BRESP_OUT == 2'h2);
endmodule
bind trig_sequencer trig_seq_props #(.NUM_LINES(NUM_LINES), .PULSE_CYCLES(PULSE_CYCLES)) props_u (.*);

// >>> verification/ext_equipment.sv
// external equipment model: drives trigger inputs, counts completion edges
`timescale 1ns/100ps
module ext_equipment (
    input wire clk,
    input wire fire,
    input wire positive,
    input wire trig_out,
    output reg trig_in,
    output reg [15:0] lines,
    output reg [7:0] completions
);
    reg last_out = 1'b1;
    initial trig_in = 1'b1;
    initial lines = 16'hffff;
    initial completions = 8'h0;
    // ==========================================
    // active level only while fire is held, so one request gives one edge
    always @(posedge clk) begin
        trig_in <= fire ? positive : !positive;
        lines <= {16{!positive}};
        last_out <= trig_out;
        if (last_out && !trig_out) completions <= completions + 8'h1;
    end
endmodule

// >>> verification/testbench.sv
// self-checking testbench for the trigger sequencer
`timescale 1ns/100ps
`include "trig_seq_map.vh"
module testbench;
    reg clk = 1'b0, rst = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    reg fire = 1'b0, positive = 1'b0;
    reg [7:0] awa = 8'h0, ara = 8'h0, base;
    reg [31:0] wd = 32'h0;
    wire awr, wr_rdy, bv, arr, rv, t_in, t_out, ready;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [15:0] l_in, l_out, l_oe;
    wire [7:0] completions;
    integer miscompares = 0, comparisons = 0, cycles = 0, i;
    always #2.5 clk = !clk;
    trig_sequencer #(.PULSE_CYCLES(8)) dut_u (.CLK_IN(clk), .RESET_IN(rst), .S_AXI_AWADDR_IN(awa),
        .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hf),
        .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr_rdy), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv),
        .S_AXI_BREADY_IN(br), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
        .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rr),
        .MAIN_TRIG_IN(t_in), .MAIN_TRIG_OUT(t_out), .DIGITAL_LINE_IN(l_in), .DIGITAL_LINE_OUT(l_out),
        .DIGITAL_LINE_OE_OUT(l_oe), .DATA_READY_OUT(ready));
    ext_equipment eq_u (.clk(clk), .fire(fire), .positive(positive), .trig_out(t_out), .trig_in(t_in),
        .lines(l_in), .completions(completions));
    // ==========================================
    // shared tasks
    task check(input [31:0] seen, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // each channel released at its own handshake edge
    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        begin
            awa <= a;
            wd <= d;
            awv <= 1'b1;
            wv <= 1'b1;
            br <= 1'b1;
            do begin
                @(posedge clk);
                if (awr === 1'b1) awv <= 1'b0;
                if (wr_rdy === 1'b1) wv <= 1'b0;
            end while (bv !== 1'b1);
            br <= 1'b0;
            check({30'h0, bresp}, {30'h0, er});
            @(posedge clk);
        end
    endtask
    task rd(input [7:0] a, input [31:0] e);
        begin
            ara <= a;
            arv <= 1'b1;
            rr <= 1'b1;
            do begin
                @(posedge clk);
                if (arr === 1'b1) arv <= 1'b0;
            end while (rv !== 1'b1);
            rr <= 1'b0;
            check(rdata, e);
            @(posedge clk);
        end
    endtask
    task pulse;
        begin
            fire <= 1'b1;
            repeat (4) @(posedge clk);
            fire <= 1'b0;
        end
    endtask
    task final_report;
        begin
            $display("comparisons %0d miscompares %0d", comparisons, miscompares);
            if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    // hang guard above the run length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            final_report;
        end
    end
    initial begin
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rd(`OFS_SRE, 32'h40);
        rd(`OFS_STYLE, 32'h15);
        rd(8'h48, 32'h19ff);
        rd(8'h4c, 32'h1afe);
        rd(8'h50, 32'h0);
        rd(`OFS_CTRL, 32'h0);
        rd(8'h34, 32'h0);
        wr(8'hfc, 32'h1, 2'h2);
        for (i = 0; i < 5; i = i + 1) wr(8'h10 + 8'h4 * i[7:0], {24'h0, i[7:0]} + 32'h3, 2'h0);
        for (i = 0; i < 5; i = i + 1) rd(8'h10 + 8'h4 * i[7:0], {24'h0, i[7:0]} + 32'h3);
        $display("test defaults done");
        wr(`OFS_CTRL, 32'h3, 2'h0);
        repeat (40) @(posedge clk);
        check({31'h0, ready}, 32'h0);
        pulse;
        while (ready !== 1'b1) @(posedge clk);
        repeat (12) @(posedge clk);
        check({24'h0, completions}, 32'h1);
        check({31'h0, t_out}, 32'h1);
        $display("test spot start done");
        wr(`OFS_PROGRAM, 32'h5a, 2'h0);
        wr(`OFS_SRE, 32'h0, 2'h0);
        wr(`OFS_COMMAND, 32'h2, 2'h0);
        rd(`OFS_SRE, 32'h40);
        rd(`OFS_HOLD, 32'h0);
        wr(`OFS_COMMAND, 32'h4, 2'h0);
        rd(`OFS_PROGRAM, 32'h5a);
        wr(`OFS_COMMAND, 32'h8, 2'h0);
        rd(`OFS_PROGRAM, 32'h0);
        $display("test reset done");
        wr(`OFS_CTRL, 32'h7, 2'h0);
        pulse;
        repeat (60) @(posedge clk);
        check({24'h0, completions}, 32'h1);
        $display("test fast spot done");
        wr(8'h48, 32'h15ff, 2'h0);
        wr(8'h4c, 32'h16fe, 2'h0);
        wr(`OFS_STYLE, 32'h16, 2'h0);
        positive <= 1'b1;
        wr(`OFS_CTRL, 32'h3, 2'h0);
        repeat (8) @(posedge clk);
        base = completions;
        pulse;
        while (t_out !== 1'b1) @(posedge clk);
        @(posedge clk);
        check({31'h0, ready}, 32'h0);
        while (ready !== 1'b1) @(posedge clk);
        check({31'h0, t_out}, 32'h0);
        repeat (4) @(posedge clk);
        check({24'h0, completions}, {24'h0, base + 8'h1});
        wr(8'h48, 32'h35ff, 2'h0);
        wr(`OFS_CTRL, 32'hc, 2'h0);
        wr(`OFS_COMMAND, 32'h1, 2'h0);
        pulse;
        repeat (40) @(posedge clk);
        check({24'h0, completions - base}, 32'h2);
        $display("test gate done");
        final_report;
    end
endmodule
